// ===== rpsc_defines.vh
// constants for the reduced system control block
// assumes a 32-bit byte-addressed system control space
`ifndef RPSC_DEFINES_VH
`define RPSC_DEFINES_VH
// implemented locations
`define RPSC_ISER      32'hE000_E100
`define RPSC_ICER      32'hE000_E180
`define RPSC_ISPR      32'hE000_E200
`define RPSC_ICPR      32'hE000_E280
`define RPSC_IPR_BASE  32'hE000_E400
`define RPSC_IPR_LAST  32'hE000_E41C
`define RPSC_AIRCR     32'hE000_ED0C
`define RPSC_HANDLER_CONTROL_STATE_REG     32'hE000_ED24
`define RPSC_DEBUG_FAULT_STATUS_REG      32'hE000_ED30
`define RPSC_DHCSR     32'hE000_EDF0
`define RPSC_PC_SAMPLE_REGISTER      32'hE000_101C
`define RPSC_WCOMP     32'hE000_1020
`define RPSC_WCTRL     32'hE000_1028
// reserved locations, read zero, writes dropped
`define RPSC_ICTR      32'hE000_E004
`define RPSC_IABR      32'hE000_E300
`define RPSC_SCR       32'hE000_ED10
`define RPSC_CCR       32'hE000_ED14
`define RPSC_HANDLER_PRIORITY_ONE     32'hE000_ED18
`define RPSC_FAULT_CATEGORY_STATUS      32'hE000_ED28
`define RPSC_HARD_FAULT_STATUS      32'hE000_ED2C
`define RPSC_MMFA      32'hE000_ED34
`define RPSC_BFA       32'hE000_ED38
`define RPSC_AUXILIARY_FAULT_STATUS      32'hE000_ED3C
`define RPSC_ATTR_LO   32'hE000_ED40
`define RPSC_ATTR_HI   32'hE000_ED7F
`define RPSC_CPAC      32'hE000_ED88
`define RPSC_SOFTWARE_INTERRUPT_TRIGGER      32'hE000_EF00
`define RPSC_MPU_LO    32'hE000_ED90
`define RPSC_MPU_HI    32'hE000_EDEF
// fields
`define RPSC_KEY       16'h05FA
`define RPSC_KEY_POS   16
`define RPSC_GRP_POS   8
`define RPSC_END_POS   15
`define RPSC_SVP_POS   15
`define RPSC_DF_HALT   0
`define RPSC_DF_SOFT_BREAKPOINT_INSTRUCTION   1
`define RPSC_DF_WATCH  2
`define RPSC_DF_EXT    4
`define RPSC_DH_EN     0
`define RPSC_DH_HALT   1
`define RPSC_DH_SHALT  17
`define RPSC_PRI_W     2
`define RPSC_SZ_HALF   2'h1
`define RPSC_SZ_WORD   2'h2
`endif

// ===== rpsc_sysctl.v
// reduced system control bank: interrupt control, fault funnel,
// fixed features and a small halting-debug unit.
// assumes bus fabric and debug port run on REF_CLK; all inputs
// are same-domain logic, so none is synchronised.
// How it works
// - sleep, config, first handler priority reserved
// - attribute id region wholly reserved
// - coprocessor gate and soft trigger reserved
// - fault category and hard fault status reserved
// - fault address and auxiliary status reserved
// - priority group field always reads zero
// - stack align, unaligned trap fixed on
// - halfword and word must be aligned
// - interrupted multi-word transfer restarts from start
// - instruction fetches little-endian only
// - no exclusive load, store or clear
// - protection unit space reserved when absent
// - every fault becomes the hard fault
// - fault status only via debug registers
// - at most 32 interrupts, type reserved
// - no active-bit register, location reserved
// - halting debug only, via debug port
// - watchpoints match data addresses only
// - optional pc sample, no trace units
// - one reset domain chosen here
// - four priority levels, two-bit field
`include "rpsc_defines.vh"
module rpsc_sysctl #(
  parameter NUM_IRQ      = 32, // at most 32
  parameter DEBUG_PRES   = 1,  // debug extension fitted
  parameter PC_SAMPLE_REGISTER_PRES    = 1,  // pc sample register fitted
  parameter MPU_PRES     = 0,  // protection unit fitted
  parameter BIG_ENDIAN   = 0   // data endianness strap
) (
  input  wire        REF_CLK,
  input  wire        RESET,
  input  wire        BUS_SEL,
  input  wire        BUS_WRITE,
  input  wire [1:0]  BUS_SIZE,
  input  wire [31:0] BUS_ADDR,
  input  wire [31:0] BUS_WDATA,
  output reg  [31:0] BUS_RDATA,
  output reg         BUS_READY,
  output reg         BUS_ERR,
  input  wire        DAP_SEL,
  input  wire        DAP_WRITE,
  input  wire [31:0] DAP_ADDR,
  input  wire [31:0] DAP_WDATA,
  output reg  [31:0] DAP_RDATA,
  output reg         DAP_READY,
  input  wire [31:0] IRQ_IN,
  input  wire        IRQ_ACK,
  input  wire [4:0]  IRQ_ACK_NUM,
  output reg         IRQ_REQ,
  output reg  [4:0]  IRQ_NUM,
  output reg  [1:0]  IRQ_PRI,
  input  wire        FAULT_MEM,
  input  wire        FAULT_BUS,
  input  wire        FAULT_USAGE,
  input  wire        EXCL_OP,
  input  wire        MW_ACTIVE,
  input  wire        MW_DEVMEM,
  input  wire        IRQ_TAKEN,
  output reg         MW_RESTART,
  output reg         HARD_FAULT,
  input  wire        SOFT_BREAKPOINT_INSTRUCTION_HIT,
  input  wire        EXT_DBG_REQ,
  input  wire        DATA_VALID,
  input  wire [31:0] DATA_ADDR,
  input  wire [31:0] PC_SAMPLE,
  input  wire        SVC_PENDING,
  output reg         HALT_REQ
);

  // software state
  reg [31:0] en_q;        // interrupt enables
  reg [31:0] pend_q;      // interrupt pending
  wire [63:0] pri_q;      // two bits per interrupt
  reg [4:0]  debug_fault_status_reg_q;      // sticky debug fault status
  reg        dbg_en_q;    // halting debug enabled
  reg        halt_c_q;    // debugger halt request
  reg [31:0] wcomp_q;     // watch address
  reg        wen_q;       // watch enable

  // valid mask for the fitted interrupt count
  localparam [31:0] IRQ_MASK = (NUM_IRQ >= 32) ? 32'hFFFF_FFFF :
    ((32'h0000_0001 << NUM_IRQ) - 32'h0000_0001);

  // reserved map, shared by both ports
  function is_rsvd;
    input [31:0] a;
    begin
      is_rsvd = 1'b0;
      if (a == `RPSC_SCR || a == `RPSC_CCR || a == `RPSC_HANDLER_PRIORITY_ONE)
        is_rsvd = 1'b1;
      else if (a >= `RPSC_ATTR_LO && a <= `RPSC_ATTR_HI)
        is_rsvd = 1'b1;
      else if (a == `RPSC_CPAC || a == `RPSC_SOFTWARE_INTERRUPT_TRIGGER)
        is_rsvd = 1'b1;
      else if (a == `RPSC_FAULT_CATEGORY_STATUS || a == `RPSC_HARD_FAULT_STATUS)
        is_rsvd = 1'b1;
      else if (a == `RPSC_MMFA || a == `RPSC_BFA ||
               a == `RPSC_AUXILIARY_FAULT_STATUS)
        is_rsvd = 1'b1;
      else if (MPU_PRES == 0 && a >= `RPSC_MPU_LO &&
               a <= `RPSC_MPU_HI)
        is_rsvd = 1'b1;
      else if (a == `RPSC_ICTR || a == `RPSC_IABR)
        is_rsvd = 1'b1;
    end
  endfunction

  // debug-only locations, visible to the debug port alone
  function is_dbg;
    input [31:0] a;
    begin
      if (DEBUG_PRES == 0)
        is_dbg = 1'b0;
      else if (a == `RPSC_HANDLER_CONTROL_STATE_REG || a == `RPSC_DEBUG_FAULT_STATUS_REG)
        is_dbg = 1'b1;
      else if (a == `RPSC_DHCSR || a == `RPSC_WCOMP)
        is_dbg = 1'b1;
      else if (a == `RPSC_WCTRL)
        is_dbg = 1'b1;
      else if (a == `RPSC_PC_SAMPLE_REGISTER && PC_SAMPLE_REGISTER_PRES != 0)
        is_dbg = 1'b1;
      else
        is_dbg = 1'b0;
    end
  endfunction

  // read mux; rsvd and unknown words read zero
  function [31:0] rd_word;
    input [31:0] a;
    input        debug_access_port;
    integer      k;
    reg   [4:0]  n;
    begin
      rd_word = 32'h0000_0000;
      n = 5'h00;
      if (is_rsvd(a))
        rd_word = 32'h0000_0000;
      else if (is_dbg(a) && !debug_access_port)
        rd_word = 32'h0000_0000;
      else if (a == `RPSC_ISER || a == `RPSC_ICER)
        rd_word = en_q;
      else if (a == `RPSC_ISPR || a == `RPSC_ICPR)
        rd_word = pend_q;
      else if (a >= `RPSC_IPR_BASE && a <= `RPSC_IPR_LAST) begin
        // only the top two bits of each byte exist
        for (k = 0; k < 4; k = k + 1) begin
          n = {a[4:2], k[1:0]};
          rd_word[8*k+6 +: 2] = pri_q[2*n +: 2];
        end
      end else if (a == `RPSC_AIRCR) begin
        // group field left at zero, only endianness shows
        rd_word[`RPSC_END_POS] = (BIG_ENDIAN != 0);
        rd_word[`RPSC_GRP_POS +: 3] = 3'h0;
      end else if (a == `RPSC_HANDLER_CONTROL_STATE_REG)
        rd_word[`RPSC_SVP_POS] = SVC_PENDING;
      else if (a == `RPSC_DEBUG_FAULT_STATUS_REG)
        rd_word[4:0] = debug_fault_status_reg_q;
      else if (a == `RPSC_DHCSR) begin
        rd_word[`RPSC_DH_EN]    = dbg_en_q;
        rd_word[`RPSC_DH_HALT]  = halt_c_q;
        rd_word[`RPSC_DH_SHALT] = HALT_REQ;
      end else if (a == `RPSC_PC_SAMPLE_REGISTER)
        rd_word = PC_SAMPLE;
      else if (a == `RPSC_WCOMP)
        rd_word = wcomp_q;
      else if (a == `RPSC_WCTRL)
        rd_word[0] = wen_q;
    end
  endfunction

  // alignment check on the system bus
  wire misalign = (BUS_SIZE == `RPSC_SZ_HALF && BUS_ADDR[0]) ||
    (BUS_SIZE == `RPSC_SZ_WORD && BUS_ADDR[1:0] != 2'h0);
  wire bus_wr  = BUS_SEL && BUS_WRITE && !misalign;
  wire dap_wr  = DAP_SEL && DAP_WRITE;

  // one write decoded from either port, debug port wins
  reg [31:0] wa;
  reg [31:0] wd;
  reg        wv;
  reg        wdap;
  always @* begin
    wa = BUS_ADDR;
    wd = BUS_WDATA;
    wv = bus_wr;
    wdap = 1'b0;
    if (dap_wr) begin
      wa = DAP_ADDR;
      wd = DAP_WDATA;
      wv = 1'b1;
      wdap = 1'b1;
    end
  end
  // writes to reserved words fall through every decode
  wire wok = wv && !is_rsvd(wa);
  wire dwok = wok && wdap && is_dbg(wa);

  // bus answer, one cycle after select
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      BUS_READY <= 1'b0;
      BUS_ERR   <= 1'b0;
      BUS_RDATA <= 32'h0000_0000;
    end else begin
      BUS_READY <= BUS_SEL;
      BUS_ERR   <= BUS_SEL && misalign;
      if (BUS_SEL && !BUS_WRITE && !misalign)
        BUS_RDATA <= rd_word(BUS_ADDR, 1'b0);
      else
        BUS_RDATA <= 32'h0000_0000;
    end
  end

  // debug port answer, one cycle after select
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      DAP_READY <= 1'b0;
      DAP_RDATA <= 32'h0000_0000;
    end else begin
      DAP_READY <= DAP_SEL;
      if (DAP_SEL && !DAP_WRITE)
        DAP_RDATA <= rd_word(DAP_ADDR, 1'b1);
      else
        DAP_RDATA <= 32'h0000_0000;
    end
  end

  // enables: set and clear views of one register
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET)
      en_q <= 32'h0000_0000;
    else if (wok && wa == `RPSC_ISER)
      en_q <= en_q | (wd & IRQ_MASK);
    else if (wok && wa == `RPSC_ICER)
      en_q <= en_q & ~wd;
  end

  // pending: a request set in the same cycle as a clear survives
  reg [31:0] pset;
  reg [31:0] pclr;
  always @* begin
    pset = IRQ_IN & IRQ_MASK;
    pclr = 32'h0000_0000;
    if (wok && wa == `RPSC_ISPR)
      pset = pset | (wd & IRQ_MASK);
    if (wok && wa == `RPSC_ICPR)
      pclr = wd;
    if (IRQ_ACK)
      pclr[IRQ_ACK_NUM] = 1'b1;
  end
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET)
      pend_q <= 32'h0000_0000;
    else
      pend_q <= (pend_q & ~pclr) | pset;
  end

  // priorities; a write keeps only bits 7:6 of each byte
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1) begin : gpri
      reg [1:0] lvl_q; // one line's level, own driver per slice
      always @(posedge REF_CLK or posedge RESET) begin
        if (RESET)
          lvl_q <= 2'h0;
        else if (wok && wa == (`RPSC_IPR_BASE + 4 * (g / 4)))
          lvl_q <= wd[8*(g%4)+6 +: 2];
      end
      assign pri_q[2*g +: 2] = lvl_q;
    end
  endgenerate

  // pick the most urgent: lowest level, then lowest number
  reg [4:0] best_n;
  reg [1:0] best_p;
  reg       best_v;
  integer   i;
  always @* begin
    best_n = 5'h00;
    best_p = 2'h3;
    best_v = 1'b0;
    for (i = 31; i >= 0; i = i - 1) begin
      if (pend_q[i] && en_q[i] &&
          (!best_v || pri_q[2*i +: 2] <= best_p)) begin
        best_v = 1'b1;
        best_p = pri_q[2*i +: 2];
        best_n = i[4:0];
      end
    end
  end
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      IRQ_REQ <= 1'b0;
      IRQ_NUM <= 5'h00;
      IRQ_PRI <= 2'h0;
    end else begin
      IRQ_REQ <= best_v;
      IRQ_NUM <= best_n;
      IRQ_PRI <= best_p;
    end
  end

  // fault funnel: one exception, no per-category record
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET)
      HARD_FAULT <= 1'b0;
    else
      HARD_FAULT <= FAULT_MEM || FAULT_BUS || FAULT_USAGE ||
                    (BUS_SEL && misalign) ||
                    EXCL_OP ||
                    (MW_ACTIVE && MW_DEVMEM);
  end

  // no continuation state: the transfer is rerun whole
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET)
      MW_RESTART <= 1'b0;
    else
      MW_RESTART <= MW_ACTIVE && IRQ_TAKEN;
  end

  // watchpoint on data address only, fetches not compared
  wire watch_hit = (DEBUG_PRES != 0) && wen_q && DATA_VALID &&
                   DATA_ADDR == wcomp_q;
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      wcomp_q <= 32'h0000_0000;
      wen_q   <= 1'b0;
    end else if (dwok && wa == `RPSC_WCOMP)
      wcomp_q <= wd;
    else if (dwok && wa == `RPSC_WCTRL)
      wen_q <= wd[0];
  end

  // halt control written by the debugger alone
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      dbg_en_q <= 1'b0;
      halt_c_q <= 1'b0;
    end else if (dwok && wa == `RPSC_DHCSR) begin
      dbg_en_q <= wd[`RPSC_DH_EN];
      halt_c_q <= wd[`RPSC_DH_HALT];
    end
  end

  // sticky status; events win over write-one-to-clear
  reg [4:0] dset;
  always @* begin
    dset = 5'h00;
    dset[`RPSC_DF_SOFT_BREAKPOINT_INSTRUCTION]  = SOFT_BREAKPOINT_INSTRUCTION_HIT && dbg_en_q;
    dset[`RPSC_DF_WATCH] = watch_hit && dbg_en_q;
    dset[`RPSC_DF_EXT]   = EXT_DBG_REQ && dbg_en_q;
    dset[`RPSC_DF_HALT]  = halt_c_q && dbg_en_q;
  end
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET)
      debug_fault_status_reg_q <= 5'h00;
    else if (dwok && wa == `RPSC_DEBUG_FAULT_STATUS_REG)
      debug_fault_status_reg_q <= (debug_fault_status_reg_q & ~wd[4:0]) | dset;
    else
      debug_fault_status_reg_q <= debug_fault_status_reg_q | dset;
  end

  // halted while any debug event stands; no monitor path
  always @(posedge REF_CLK or posedge RESET) begin
    if (RESET)
      HALT_REQ <= 1'b0;
    else
      HALT_REQ <= dbg_en_q && (halt_c_q || dset != 5'h00 ||
                  (HALT_REQ && debug_fault_status_reg_q != 5'h00));
  end

  // fetch data leaves untouched: little-endian only, any
  // halfword swap is the fabric's job

endmodule

// ===== rpsc_sysctl_asserts.sv
// checker for the reduced system control bank, bound onto rpsc_sysctl
// assumes one clock domain and the default strap parameters
`include "rpsc_defines.vh"
module rpsc_sysctl_chk (
  input wire logic        REF_CLK,
  input wire logic        RESET,
  input wire logic        BUS_SEL,
  input wire logic        BUS_WRITE,
  input wire logic [1:0]  BUS_SIZE,
  input wire logic [31:0] BUS_ADDR,
  input wire logic [31:0] BUS_RDATA,
  input wire logic        BUS_READY,
  input wire logic        BUS_ERR,
  input wire logic        DAP_SEL,
  input wire logic        DAP_READY,
  input wire logic        FAULT_MEM,
  input wire logic        FAULT_BUS,
  input wire logic        FAULT_USAGE,
  input wire logic        EXCL_OP,
  input wire logic        MW_ACTIVE,
  input wire logic        MW_DEVMEM,
  input wire logic        IRQ_TAKEN,
  input wire logic        MW_RESTART,
  input wire logic        HARD_FAULT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  // reserved places, protection unit absent
  function automatic bit rsv(input logic [31:0] a);
    return a inside {`RPSC_ICTR, `RPSC_IABR, `RPSC_SCR, `RPSC_CCR,
      `RPSC_HANDLER_PRIORITY_ONE, `RPSC_FAULT_CATEGORY_STATUS, `RPSC_HARD_FAULT_STATUS, `RPSC_MMFA, `RPSC_BFA,
      `RPSC_AUXILIARY_FAULT_STATUS, `RPSC_CPAC, `RPSC_SOFTWARE_INTERRUPT_TRIGGER, [`RPSC_MPU_LO:`RPSC_MPU_HI]};
  endfunction
  wire mis = BUS_SEL && ((BUS_SIZE == `RPSC_SZ_HALF && BUS_ADDR[0]) ||
    (BUS_SIZE == `RPSC_SZ_WORD && BUS_ADDR[1:0] != 2'h0)); // misaligned
  wire rd = BUS_SEL && !BUS_WRITE && !mis; // aligned read
  wire cause = FAULT_MEM | FAULT_BUS | FAULT_USAGE | EXCL_OP |
    (MW_ACTIVE & MW_DEVMEM); // any fault but misalignment
  wire mw_hit = MW_ACTIVE && IRQ_TAKEN; // interrupted transfer
  // a zero answer, no error
  sequence s_ans0;
    BUS_READY && BUS_RDATA == 32'h0000_0000 && !BUS_ERR;
  endsequence
  sequence s_rd_rsv;
    rd && rsv(BUS_ADDR);
  endsequence
  property p_rsv_rd;
    s_rd_rsv |=> s_ans0;
  endproperty
  a_rsv_rd: assert property (p_rsv_rd)
    else $error("reserved read not zero");
  property p_attr;
    rd && BUS_ADDR inside {[`RPSC_ATTR_LO:`RPSC_ATTR_HI]} |=> s_ans0;
  endproperty
  a_attr: assert property (p_attr)
    else $error("attribute region read not zero");
  property p_grp;
    rd && BUS_ADDR == `RPSC_AIRCR |=> BUS_READY && BUS_RDATA[14:0] == 15'h0000;
  endproperty
  a_grp: assert property (p_grp)
    else $error("grouping field not zero");
  property p_misal;
    mis |=> BUS_READY && BUS_ERR && BUS_RDATA == 32'h0000_0000;
  endproperty
  a_misal: assert property (p_misal)
    else $error("misaligned access not refused");
  property p_algn;
    BUS_SEL && !mis |=> !BUS_ERR;
  endproperty
  a_algn: assert property (p_algn)
    else $error("aligned access refused");
  property p_fault;
    cause |=> HARD_FAULT;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault cause not escalated");
  property p_calm;
    !cause && !mis |=> !HARD_FAULT;
  endproperty
  a_calm: assert property (p_calm)
    else $error("hard fault without cause");
  property p_mw;
    mw_hit |=> MW_RESTART ##1 MW_RESTART == $past(mw_hit);
  endproperty
  a_mw: assert property (p_mw)
    else $error("interrupted transfer not restarted");
  property p_mw0;
    !(MW_ACTIVE && IRQ_TAKEN) |=> !MW_RESTART;
  endproperty
  a_mw0: assert property (p_mw0)
    else $error("restart without interrupted transfer");
  property p_dap;
    DAP_SEL |=> DAP_READY;
  endproperty
  a_dap: assert property (p_dap)
    else $error("debug port not answered");
  property p_dbg_bus;
    rd && BUS_ADDR inside {`RPSC_DEBUG_FAULT_STATUS_REG, `RPSC_DHCSR} |=> s_ans0;
  endproperty
  a_dbg_bus: assert property (p_dbg_bus)
    else $error("debug register visible from bus");
endmodule
bind rpsc_sysctl rpsc_sysctl_chk u_chk (.REF_CLK, .RESET, .BUS_SEL,
  .BUS_WRITE, .BUS_SIZE, .BUS_ADDR, .BUS_RDATA, .BUS_READY, .BUS_ERR,
  .DAP_SEL, .DAP_READY, .FAULT_MEM, .FAULT_BUS, .FAULT_USAGE, .EXCL_OP,
  .MW_ACTIVE, .MW_DEVMEM, .IRQ_TAKEN, .MW_RESTART, .HARD_FAULT);

// ===== rpsc_fabric.sv
// bus fabric and debug port model driving the system control bank
// assumes an answer one cycle after each taken request
module rpsc_fabric (
  input  wire logic        REF_CLK,
  output logic             BUS_SEL,
  output logic             BUS_WRITE,
  output logic [1:0]       BUS_SIZE,
  output logic [31:0]      BUS_ADDR,
  output logic [31:0]      BUS_WDATA,
  input  wire logic [31:0] BUS_RDATA,
  input  wire logic        BUS_READY,
  input  wire logic        BUS_ERR,
  output logic             DAP_SEL,
  output logic             DAP_WRITE,
  output logic [31:0]      DAP_ADDR,
  output logic [31:0]      DAP_WDATA,
  input  wire logic [31:0] DAP_RDATA,
  input  wire logic        DAP_READY
);
  timeunit 1ns;
  timeprecision 100ps;
  // both masters idle from time zero
  initial begin
    {BUS_SEL, BUS_WRITE, BUS_SIZE, BUS_ADDR, BUS_WDATA} = '0;
    {DAP_SEL, DAP_WRITE, DAP_ADDR, DAP_WDATA} = '0;
  end
  // halfword byte swap for fetch beats only, data never swapped
  function automatic logic [31:0] fetch_swap(input logic [31:0] d);
    return {d[23:16], d[31:24], d[7:0], d[15:8]};
  endfunction
  // one bus access: select is a level, so it stands for one edge only
  task automatic acc(input logic w, input logic [1:0] sz,
    input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e, output logic r);
    {BUS_SEL, BUS_WRITE, BUS_SIZE, BUS_ADDR, BUS_WDATA} = {1'b1, w, sz, a, d};
    @(posedge REF_CLK);
    #1;
    BUS_SEL = 1'b0;
    BUS_ADDR = ~a; // released lines carry no stale value
    BUS_WDATA = ~d;
    {q, e, r} = {BUS_RDATA, BUS_ERR, BUS_READY};
    @(posedge REF_CLK);
    #1;
  endtask
  // one debug port access, same timing
  task automatic debug_access_port(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic r);
    {DAP_SEL, DAP_WRITE, DAP_ADDR, DAP_WDATA} = {1'b1, w, a, d};
    @(posedge REF_CLK);
    #1;
    DAP_SEL = 1'b0;
    DAP_ADDR = ~a;
    DAP_WDATA = ~d;
    {q, r} = {DAP_RDATA, DAP_READY};
    @(posedge REF_CLK);
    #1;
  endtask
endmodule

// ===== tb_reduced_profile_system_control.sv
// self-checking bench for the reduced system control bank
// assumes the fabric model and the bound checker are compiled too
`include "rpsc_defines.vh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  err_count++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_reduced_profile_system_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic REF_CLK, RESET, BUS_SEL, BUS_WRITE, BUS_READY, BUS_ERR;
  logic DAP_SEL, DAP_WRITE, DAP_READY, IRQ_ACK, IRQ_REQ, HALT_REQ;
  logic FAULT_MEM, FAULT_BUS, FAULT_USAGE, EXCL_OP, HARD_FAULT;
  logic MW_ACTIVE, MW_DEVMEM, IRQ_TAKEN, MW_RESTART, SVC_PENDING;
  logic SOFT_BREAKPOINT_INSTRUCTION_HIT, EXT_DBG_REQ, DATA_VALID, e, r;
  logic [1:0]  BUS_SIZE, IRQ_PRI;
  logic [4:0]  IRQ_ACK_NUM, IRQ_NUM;
  logic [31:0] BUS_ADDR, BUS_WDATA, BUS_RDATA, DAP_ADDR, DAP_WDATA, q;
  logic [31:0] DAP_RDATA, IRQ_IN, DATA_ADDR, PC_SAMPLE;
  int          err_count, n_checks;
  rpsc_sysctl DUT (.REF_CLK, .RESET, .BUS_SEL, .BUS_WRITE, .BUS_SIZE,
    .BUS_ADDR, .BUS_WDATA, .BUS_RDATA, .BUS_READY, .BUS_ERR, .DAP_SEL,
    .DAP_WRITE, .DAP_ADDR, .DAP_WDATA, .DAP_RDATA, .DAP_READY, .IRQ_IN,
    .IRQ_ACK, .IRQ_ACK_NUM, .IRQ_REQ, .IRQ_NUM, .IRQ_PRI, .FAULT_MEM,
    .FAULT_BUS, .FAULT_USAGE, .EXCL_OP, .MW_ACTIVE, .MW_DEVMEM, .IRQ_TAKEN,
    .MW_RESTART, .HARD_FAULT, .SOFT_BREAKPOINT_INSTRUCTION_HIT, .EXT_DBG_REQ, .DATA_VALID,
    .DATA_ADDR, .PC_SAMPLE, .SVC_PENDING, .HALT_REQ);
  rpsc_fabric fab (.REF_CLK, .BUS_SEL, .BUS_WRITE, .BUS_SIZE, .BUS_ADDR,
    .BUS_WDATA, .BUS_RDATA, .BUS_READY, .BUS_ERR, .DAP_SEL, .DAP_WRITE,
    .DAP_ADDR, .DAP_WDATA, .DAP_RDATA, .DAP_READY);
  // 50 MHz clock
  always #10 REF_CLK = ~REF_CLK;
  // one edge passes, inputs move just after it
  task automatic tick();
    @(posedge REF_CLK);
    #1;
  endtask
  // each listed reserved place reads zero after a write of ones; the attribute top byte is only read
  task automatic t_reserved();
    logic [31:0] tbl [15] = '{`RPSC_ICTR, `RPSC_IABR, `RPSC_SCR, `RPSC_CCR,
      `RPSC_HANDLER_PRIORITY_ONE, `RPSC_FAULT_CATEGORY_STATUS, `RPSC_HARD_FAULT_STATUS, `RPSC_MMFA, `RPSC_BFA, `RPSC_AUXILIARY_FAULT_STATUS,
      `RPSC_ATTR_LO, 32'hE000_ED7C, `RPSC_CPAC, `RPSC_SOFTWARE_INTERRUPT_TRIGGER, `RPSC_MPU_LO};
    foreach (tbl[i]) begin
      fab.acc(1'b1, `RPSC_SZ_WORD, tbl[i], 32'hFFFF_FFFF, q, e, r);
      fab.acc(1'b0, `RPSC_SZ_WORD, tbl[i], 32'h0000_0000, q, e, r);
      `CHK("rsv", 32'h0000_0000, q)
      `CHK("rsv_rdy", 1'b1, r)
    end
    fab.acc(1'b0, 2'h0, `RPSC_ATTR_HI, 32'h0000_0000, q, e, r);
    `CHK("attr_top", 32'h0000_0000, q)
  endtask
  // grouping and fixed features have no writable control
  task automatic t_aircr();
    fab.acc(1'b1, `RPSC_SZ_WORD, `RPSC_AIRCR, 32'h05FA_0700, q, e, r);
    fab.acc(1'b0, `RPSC_SZ_WORD, `RPSC_AIRCR, 32'h0000_0000, q, e, r);
    `CHK("aircr", 32'h0000_0000, q)
  endtask
  // misaligned half and word refused, priority keeps two bits
  task automatic t_align();
    fab.acc(1'b0, `RPSC_SZ_HALF, `RPSC_IPR_BASE + 1, 32'h0000_0000, q, e, r);
    `CHK("half_odd", 1'b1, e)
    fab.acc(1'b1, `RPSC_SZ_WORD, `RPSC_IPR_BASE + 2, 32'hFFFF_FFFF, q, e, r);
    `CHK("word_odd", 1'b1, e)
    fab.acc(1'b0, `RPSC_SZ_WORD, `RPSC_IPR_BASE, 32'h0000_0000, q, e, r);
    `CHK("dropped", 32'h0000_0000, q)
    fab.acc(1'b1, `RPSC_SZ_WORD, `RPSC_IPR_BASE, 32'hFFFF_FFFF, q, e, r);
    fab.acc(1'b0, `RPSC_SZ_WORD, `RPSC_IPR_BASE, 32'h0000_0000, q, e, r);
    `CHK("prio", 32'hC0C0_C0C0, q)
    `CHK("aligned", 1'b0, e)
  endtask
  // each fault category lands on the one hard fault
  task automatic t_fault();
    for (int i = 0; i < 4; i++) begin
      {EXCL_OP, FAULT_USAGE, FAULT_BUS, FAULT_MEM} = 4'h1 << i;
      tick();
      {EXCL_OP, FAULT_USAGE, FAULT_BUS, FAULT_MEM} = 4'h0;
      `CHK("hard", 1'b1, HARD_FAULT)
      tick();
      `CHK("hard_end", 1'b0, HARD_FAULT)
    end
  endtask
  // interrupted multi-word transfer reruns, quiet one does not
  task automatic t_mw();
    {MW_ACTIVE, MW_DEVMEM} = 2'h3;
    tick();
    MW_DEVMEM = 1'b0;
    `CHK("mw_dev", 1'b1, HARD_FAULT)
    `CHK("mw_quiet", 1'b0, MW_RESTART)
    IRQ_TAKEN = 1'b1;
    tick();
    {IRQ_TAKEN, MW_ACTIVE} = 2'h0;
    `CHK("mw_rerun", 1'b1, MW_RESTART)
  endtask
  // top line of 32 enabled, raised, acked; a disabled line stays quiet
  task automatic t_irq();
    fab.acc(1'b1, `RPSC_SZ_WORD, `RPSC_ISER, 32'h8000_0000, q, e, r);
    IRQ_IN = 32'h8000_0000;
    tick();
    IRQ_IN = 32'h0000_0001;
    tick();
    IRQ_IN = 32'h0000_0000;
    `CHK("irq_req", 1'b1, IRQ_REQ)
    `CHK("irq_num", 5'h1F, IRQ_NUM)
    `CHK("irq_pri31", 2'h0, IRQ_PRI)
    {IRQ_ACK, IRQ_ACK_NUM} = {1'b1, 5'h1F};
    tick();
    IRQ_ACK = 1'b0;
    repeat (2) tick();
    `CHK("irq_gone", 1'b0, IRQ_REQ)
    // line 0 still pending at level 3 from the priority write
    fab.acc(1'b1, `RPSC_SZ_WORD, `RPSC_ISER, 32'h0000_0001, q, e, r);
    `CHK("irq_low", 5'h00, IRQ_NUM)
    `CHK("irq_pri0", 2'h3, IRQ_PRI)
  endtask
  // halting debug through the port, address-only watchpoint
  task automatic t_dbg();
    fab.debug_access_port(1'b1, `RPSC_DHCSR, 32'h0000_0001, q, r);
    SOFT_BREAKPOINT_INSTRUCTION_HIT = 1'b1;
    tick();
    SOFT_BREAKPOINT_INSTRUCTION_HIT = 1'b0;
    `CHK("halt", 1'b1, HALT_REQ)
    fab.debug_access_port(1'b0, `RPSC_DEBUG_FAULT_STATUS_REG, 32'h0000_0000, q, r);
    `CHK("debug_fault_status_reg_soft_breakpoint_instruction", 1'b1, q[1])
    fab.acc(1'b0, `RPSC_SZ_WORD, `RPSC_DEBUG_FAULT_STATUS_REG, 32'h0000_0000, q, e, r);
    `CHK("debug_fault_status_reg_bus", 32'h0000_0000, q)
    fab.debug_access_port(1'b1, `RPSC_DEBUG_FAULT_STATUS_REG, 32'h0000_001F, q, r);
    fab.debug_access_port(1'b1, `RPSC_WCOMP, 32'h2000_0040, q, r);
    fab.debug_access_port(1'b1, `RPSC_WCTRL, 32'h0000_0001, q, r);
    {DATA_VALID, DATA_ADDR, EXT_DBG_REQ} = {1'b1, 32'h2000_0044, 1'b1};
    tick();
    {DATA_VALID, EXT_DBG_REQ} = 2'h0;
    fab.debug_access_port(1'b0, `RPSC_DEBUG_FAULT_STATUS_REG, 32'h0000_0000, q, r);
    `CHK("no_watch", 2'h2, {q[4], q[2]})
    {DATA_VALID, DATA_ADDR} = {1'b1, 32'h2000_0040};
    tick();
    DATA_VALID = 1'b0;
    fab.debug_access_port(1'b0, `RPSC_DEBUG_FAULT_STATUS_REG, 32'h0000_0000, q, r);
    `CHK("watch", 1'b1, q[2])
    fab.debug_access_port(1'b0, `RPSC_PC_SAMPLE_REGISTER, 32'h0000_0000, q, r);
    `CHK("pc_sample", PC_SAMPLE, q)
    SVC_PENDING = 1'b1;
    fab.debug_access_port(1'b0, `RPSC_HANDLER_CONTROL_STATE_REG, 32'h0000_0000, q, r);
    SVC_PENDING = 1'b0;
    `CHK("handler_control_state_reg", 32'h0000_8000, q)
    `CHK("fetch_swap", 32'h2211_4433, fab.fetch_swap(32'h1122_3344))
  endtask
  // counts, verdict, end of run
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence, one reset domain
  initial begin
    {REF_CLK, RESET, IRQ_IN, IRQ_ACK, IRQ_ACK_NUM, FAULT_MEM} = '0;
    {FAULT_BUS, FAULT_USAGE, EXCL_OP, MW_ACTIVE, IRQ_TAKEN} = '0;
    {SOFT_BREAKPOINT_INSTRUCTION_HIT, EXT_DBG_REQ, DATA_VALID, DATA_ADDR, SVC_PENDING} = '0;
    MW_DEVMEM = 1'b0;
    PC_SAMPLE = 32'h0000_1234;
    RESET = 1'b1;
    repeat (16) @(posedge REF_CLK);
    #1;
    RESET = 1'b0;
    tick();
    t_reserved();
    t_aircr();
    t_align();
    t_fault();
    t_mw();
    t_irq();
    t_dbg();
    stop_test();
  end
  // hang guard, far beyond the roughly 135 cycles needed
  initial begin
    #100_000;
    err_count++;
    stop_test();
  end
endmodule
